// ---- verilog/ddc_regs.svh ----
// register offsets, field positions and reset values of the datapath config slice
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH

// register indices; byte address is four times the index
`define DDC_IDX_FORMAT 6'h02
`define DDC_IDX_SCALE 6'h03
`define DDC_IDX_RESULT 6'h04

// datapath format control fields
`define DDC_FMT_CLKGONE_MSB 14
`define DDC_FMT_CLKGONE_LSB 12
`define DDC_FMT_FOUR_WIRE 7
`define DDC_FMT_MIXER_EN 6
`define DDC_FMT_MIXER_GAIN 5
`define DDC_FMT_NCO_EN 4
`define DDC_FMT_REV_BUS 3
`define DDC_FMT_TWOS 1
`define DDC_FMT_WMASK 16'h70fa
`define DDC_FMT_RESET 16'h7000

// current scale and transmit control fields
`define DDC_SCL_MSB 15
`define DDC_SCL_LSB 12
`define DDC_SCL_TX 0
`define DDC_SCL_WMASK 16'hf001
`define DDC_SCL_RESET 16'hf000

// pattern check failures
`define DDC_RES_RESET 16'h0000

// bus decode
`define DDC_AHB_OKAY 1'b0
`define DDC_HTRANS_NONSEQ 2'b10
`define DDC_HSIZE_WORD 3'b010

`endif

// ---- verilog/ddc_pkg.sv ----
// types shared by the datapath config slice
package ddc_pkg;

   // decoded control bits of the two control registers
   typedef struct packed {
      logic four_wire;
      logic mixer_en;
      logic mixer_gain;
      logic nco_en;
      logic rev_bus;
      logic twos;
      logic [2:0] gone_en;
      logic [3:0] scale;
      logic sw_tx;
   } ddc_ctrl_t;

   // one register write from the bus slave
   typedef struct packed {
      logic valid;
      logic hit;
      logic [5:0] idx;
      logic [15:0] data;
   } ddc_wr_t;

   // data phase of the bus slave
   typedef enum logic [1:0] {
      DDC_S_IDLE,
      DDC_S_WRITE,
      DDC_S_READ_WAIT,
      DDC_S_READ_DATA
   } ddc_slave_state_t;

endpackage

// ---- verilog/ddc_ahb_slave.sv ----
// ahb-lite slave: zero-wait writes, one-wait reads
`timescale 1ns/10ps
`default_nettype none
`include "ddc_regs.svh"

module ddc_ahb_slave
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // register side
   output ddc_pkg::ddc_wr_t wr,
   output logic [5:0] rd_idx,
   output logic rd_hit,
   input wire logic [15:0] rd_data
);

   ddc_pkg::ddc_slave_state_t state;
   logic take;
   logic addr_ok;

   // an address phase is taken when the slave is selected, the bus is ready and a nonsequential transfer of any size starts
   assign take = hsel && hready && (htrans == `DDC_HTRANS_NONSEQ);
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00)
                    && (hsize == `DDC_HSIZE_WORD);

   // data phase sequencing and address capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= ddc_pkg::DDC_S_IDLE;
         rd_idx <= 6'h00;
         rd_hit <= 1'b0;
      end
      else if (take)
      begin
         state <= hwrite ? ddc_pkg::DDC_S_WRITE : ddc_pkg::DDC_S_READ_WAIT;
         rd_idx <= haddr[7:2];
         rd_hit <= addr_ok;
      end
      else
      begin
         case (state)
            ddc_pkg::DDC_S_READ_WAIT: state <= ddc_pkg::DDC_S_READ_DATA;
            ddc_pkg::DDC_S_WRITE: state <= ddc_pkg::DDC_S_IDLE;
            ddc_pkg::DDC_S_READ_DATA: state <= ddc_pkg::DDC_S_IDLE;
            default: state <= ddc_pkg::DDC_S_IDLE;
         endcase
      end
   end

   // ready, response and read data flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= `DDC_AHB_OKAY;
         hrdata <= 32'h00000000;
      end
      else
      begin
         hresp <= `DDC_AHB_OKAY;
         hreadyout <= !(take && !hwrite);
         if (state == ddc_pkg::DDC_S_READ_WAIT)
         begin
            hrdata <= rd_hit ? {16'h0000, rd_data} : 32'h00000000;
         end
      end
   end

   // write strobe stands for the single data phase cycle
   assign wr.valid = (state == ddc_pkg::DDC_S_WRITE);
   assign wr.hit = rd_hit;
   assign wr.idx = rd_idx;
   assign wr.data = hwdata[15:0];

endmodule
`default_nettype wire

// ---- verilog/ddc_lane_cond.sv ----
// input lane conditioning: bit reversal and number format
`timescale 1ns/10ps
`default_nettype none

module ddc_lane_cond
#(
   parameter int W = 16
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // lane
   input wire logic [W-1:0] raw,
   input wire logic rev_bus,
   input wire logic twos,
   output logic [W-1:0] sample
);

   generate
      if (W < 2)
      begin : g_chk
         $error("ddc_lane_cond: W must be at least 2");
      end
   endgenerate

   // mirror the bit order of a word
   function automatic logic [W-1:0] mirror(input logic [W-1:0] v);
      logic [W-1:0] r;
      r = '0;
      for (int i = 0; i < W; i++)
      begin
         r[i] = v[W-1-i];
      end
      return r;
   endfunction

   logic [W-1:0] ordered;

   // reversal happens before the format is interpreted
   assign ordered = rev_bus ? mirror(raw) : raw;

   // offset binary becomes two's complement by flipping the top bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sample <= '0;
      end
      else
      begin
         sample <= twos ? ordered : {~ordered[W-1], ordered[W-2:0]};
      end
   end

endmodule
`default_nettype wire

// ---- verilog/ddc_top.sv ----
// datapath configuration registers with input conditioning and pattern check
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_regs.svh"

// Function
// - port-width bit one selects four-wire serial port, zero three-wire
// - mixing-stage enable bit switches the mixer on; off by default
// - mixer gain bit adds 6dB to mixer output samples
// - oscillator enable turns the oscillator on; coarse mixing works without it
// - bus reversal bit mirrors the bit order of each input word
// - format bit one means two's complement, zero offset binary (default)
// - four-bit current scale in upper nibble, sixteen steps, largest after reset
// - scale and transmit register resets to 0xf000, transmit bit cleared
// - internal transmit enable is software bit OR transmit pin
// - during pattern check a mismatch on either bus sets its result bit
// - result bit n covers input line n of both buses
// - result bits are cleared by writing ones to them
// - format control register at index two resets to 0x7000
module ddc_top
#(
   parameter int W = 16
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // input data buses from pins
   input wire logic [W-1:0] first_input_bus,
   input wire logic [W-1:0] second_input_bus,
   // transmit pin
   input wire logic transmit_on_pin,
   // pattern checker control from datapath logic
   input wire logic pattern_check_active,
   input wire logic [W-1:0] expected_first,
   input wire logic [W-1:0] expected_second,
   // mixer samples from datapath logic
   input wire logic [W-1:0] mixer_in,
   // conditioned samples
   output logic [W-1:0] first_sample,
   output logic [W-1:0] second_sample,
   output logic [W-1:0] mixer_out,
   // controls to the rest of the device
   output logic serial_port_four_wire_select,
   output logic mixer_enable,
   output logic coarse_mix_enable,
   output logic nco_enable,
   output logic [3:0] current_scale,
   output logic [2:0] clock_gone_enables,
   output logic transmit_enable
);

   generate
      if (W != 16)
      begin : g_chk
         $error("ddc_top: register layout serves a 16-bit bus only");
      end
   endgenerate

   // saturating doubling of a two's complement sample
   function automatic logic [W-1:0] sat_double(input logic [W-1:0] v);
      logic [W-1:0] r;
      r = {v[W-2:0], 1'b0};
      if (v[W-1] != v[W-2])
      begin
         r = v[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      end
      return r;
   endfunction

   // true when a write strobe addresses the given register
   function automatic logic wr_to(input ddc_pkg::ddc_wr_t w, input logic [5:0] idx);
      return w.valid && w.hit && (w.idx == idx);
   endfunction

   ddc_pkg::ddc_wr_t wr;
   logic [5:0] rd_idx;
   logic rd_hit;
   logic [15:0] rd_data;
   logic [15:0] fmt_reg;
   logic [15:0] scl_reg;
   logic [W-1:0] result;
   ddc_pkg::ddc_ctrl_t ctrl;
   logic [W-1:0] first_meta;
   logic [W-1:0] first_sync;
   logic [W-1:0] second_meta;
   logic [W-1:0] second_sync;
   logic tx_meta;
   logic tx_sync;
   logic [W-1:0] mismatch;
   logic [W-1:0] clear_bits;
   logic [W-1:0] next_result;

   // bus slave
   ddc_ahb_slave u_slave
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .wr(wr),
      .rd_idx(rd_idx),
      .rd_hit(rd_hit),
      .rd_data(rd_data)
   );

   // format control register; reserved bits are not stored
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fmt_reg <= `DDC_FMT_RESET;
      end
      else if (wr_to(wr, `DDC_IDX_FORMAT))
      begin
         fmt_reg <= wr.data & `DDC_FMT_WMASK;
      end
   end

   // current scale and transmit control register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_reg <= `DDC_SCL_RESET;
      end
      else if (wr_to(wr, `DDC_IDX_SCALE))
      begin
         scl_reg <= wr.data & `DDC_SCL_WMASK;
      end
   end

   // decode the stored fields
   assign ctrl.four_wire = fmt_reg[`DDC_FMT_FOUR_WIRE];
   assign ctrl.mixer_en = fmt_reg[`DDC_FMT_MIXER_EN];
   assign ctrl.mixer_gain = fmt_reg[`DDC_FMT_MIXER_GAIN];
   assign ctrl.nco_en = fmt_reg[`DDC_FMT_NCO_EN];
   assign ctrl.rev_bus = fmt_reg[`DDC_FMT_REV_BUS];
   assign ctrl.twos = fmt_reg[`DDC_FMT_TWOS];
   assign ctrl.gone_en = fmt_reg[`DDC_FMT_CLKGONE_MSB:`DDC_FMT_CLKGONE_LSB];
   assign ctrl.scale = scl_reg[`DDC_SCL_MSB:`DDC_SCL_LSB];
   assign ctrl.sw_tx = scl_reg[`DDC_SCL_TX];

   // read mux; unmapped words read zero
   always_comb
   begin
      case (rd_idx)
         `DDC_IDX_FORMAT: rd_data = fmt_reg;
         `DDC_IDX_SCALE: rd_data = scl_reg;
         `DDC_IDX_RESULT: rd_data = result;
         default: rd_data = 16'h0000;
      endcase
   end

   // two-flop synchronisers for the pin inputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         first_meta <= '0;
         first_sync <= '0;
         second_meta <= '0;
         second_sync <= '0;
         tx_meta <= 1'b0;
         tx_sync <= 1'b0;
      end
      else
      begin
         first_meta <= first_input_bus;
         first_sync <= first_meta;
         second_meta <= second_input_bus;
         second_sync <= second_meta;
         tx_meta <= transmit_on_pin;
         tx_sync <= tx_meta;
      end
   end

   // line n of both buses folds into result bit n
   assign mismatch = pattern_check_active ?
                     ((first_sync ^ expected_first) | (second_sync ^ expected_second)) :
                     '0;

   // written ones clear their bits; a fresh mismatch wins over the clear
   assign clear_bits = wr_to(wr, `DDC_IDX_RESULT) ? wr.data : '0;
   assign next_result = (result & ~clear_bits) | mismatch;

   // pattern check failure record
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         result <= `DDC_RES_RESET;
      end
      else
      begin
         result <= next_result;
      end
   end

   // first bus conditioning
   ddc_lane_cond #(.W(W)) u_first
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(first_sync),
      .rev_bus(ctrl.rev_bus),
      .twos(ctrl.twos),
      .sample(first_sample)
   );

   // second bus conditioning
   ddc_lane_cond #(.W(W)) u_second
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(second_sync),
      .rev_bus(ctrl.rev_bus),
      .twos(ctrl.twos),
      .sample(second_sample)
   );

   // mixer output stage with optional 6db gain; silent while disabled
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mixer_out <= '0;
      end
      else if (!ctrl.mixer_en)
      begin
         mixer_out <= '0;
      end
      else
      begin
         mixer_out <= ctrl.mixer_gain ? sat_double(mixer_in) : mixer_in;
      end
   end

   // registered control outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         serial_port_four_wire_select <= 1'b0;
         mixer_enable <= 1'b0;
         coarse_mix_enable <= 1'b0;
         nco_enable <= 1'b0;
         current_scale <= 4'h0;
         clock_gone_enables <= 3'h0;
      end
      else
      begin
         serial_port_four_wire_select <= ctrl.four_wire;
         mixer_enable <= ctrl.mixer_en;
         coarse_mix_enable <= ctrl.mixer_en;
         nco_enable <= ctrl.nco_en;
         current_scale <= ctrl.scale;
         clock_gone_enables <= ctrl.gone_en;
      end
   end

   // output transmission is on if either software or the pin asks for it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         transmit_enable <= 1'b0;
      end
      else
      begin
         transmit_enable <= ctrl.sw_tx | tx_sync;
      end
   end

endmodule
`default_nettype wire

// ---- tb/ddc_checker_assertions.sv ----
// concurrent checks on the ports of the datapath config slice
`timescale 1ns/10ps
`default_nettype none

module ddc_checker
#(
   parameter int W = 16
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   // pin and datapath
   input wire logic transmit_on_pin,
   input wire logic [W-1:0] mixer_out,
   // controls
   input wire logic serial_port_four_wire_select,
   input wire logic mixer_enable,
   input wire logic coarse_mix_enable,
   input wire logic nco_enable,
   input wire logic [3:0] current_scale,
   input wire logic [2:0] clock_gone_enables,
   input wire logic transmit_enable
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // a held pin reaches the enable through the synchroniser
   property p_tx_pin;
      transmit_on_pin [*3] |=> transmit_enable;
   endproperty
   a_tx_pin: assert property (p_tx_pin) else $error("transmit pin ignored");

   // no transmit out of reset while the pin is low
   property p_tx_rst;
      ($rose(hresetn) && !transmit_on_pin) |=> !transmit_enable;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("transmit set after reset");

   // largest scale out of reset
   property p_scale_rst;
      $rose(hresetn) |=> current_scale == 4'hf;
   endproperty
   a_scale_rst: assert property (p_scale_rst) else $error("scale reset wrong");

   // format controls out of reset
   property p_fmt_rst;
      $rose(hresetn) |=> clock_gone_enables == 3'b111 && !serial_port_four_wire_select
         && !nco_enable && !mixer_enable;
   endproperty
   a_fmt_rst: assert property (p_fmt_rst) else $error("format reset wrong");

   // a disabled mixer gives silence
   property p_mix_off;
      !mixer_enable [*2] |-> mixer_out == '0;
   endproperty
   a_mix_off: assert property (p_mix_off) else $error("mixer output while off");

   // coarse mixing does not wait for the oscillator
   property p_coarse;
      coarse_mix_enable == mixer_enable;
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse mix tied wrong");

   // scale moves only after a write
   property p_scale_hold;
      !(hsel && hready && hwrite && htrans == 2'b10) [*4] |-> $stable(current_scale);
   endproperty
   a_scale_hold: assert property (p_scale_hold) else $error("scale moved alone");

   // reads take one wait state
   property p_read_wait;
      (hsel && hready && htrans == 2'b10 && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

   c_read: cover property (hsel && hready && htrans == 2'b10 && !hwrite);
   c_tx: cover property (transmit_enable && !transmit_on_pin);
   c_mix: cover property (mixer_enable && mixer_out != '0);
endmodule

bind ddc_top ddc_checker #(.W(W)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .transmit_on_pin(transmit_on_pin), .mixer_out(mixer_out),
   .serial_port_four_wire_select(serial_port_four_wire_select), .mixer_enable(mixer_enable),
   .coarse_mix_enable(coarse_mix_enable), .nco_enable(nco_enable),
   .current_scale(current_scale), .clock_gone_enables(clock_gone_enables),
   .transmit_enable(transmit_enable));

`default_nettype wire

// ---- tb/ddc_host.sv ----
// ahb-lite host model issuing single word transfers
`timescale 1ns/10ps
`default_nettype none

module ddc_host
(
   // clock
   input wire logic hclk,
   // answer from the slave
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // idle bus from time zero
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end

   // one transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge hclk);
      while (!hreadyout)
         @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout)
         @(posedge hclk);
      q = hrdata;
   endtask
endmodule

`default_nettype wire

// ---- tb/ddc_top_tb.sv ----
// self-checking bench for the datapath config slice
`timescale 1ns/10ps
`default_nettype none
`include "ddc_regs.svh"

module ddc_top_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, pin = 1'b0, act = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize, gone;
   logic [3:0] scale;
   logic [31:0] haddr, hwdata, hrdata, r, q;
   logic [15:0] b1 = '0, b2 = '0, e1 = '0, e2 = '0, mi = '0, s1, s2, mo;
   logic four, mix, coarse, nco, txen;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 32'hbce1;

   // free running bus clock
   always #20 hclk = ~hclk;

   ddc_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   ddc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_input_bus(b1),
      .second_input_bus(b2), .transmit_on_pin(pin), .pattern_check_active(act),
      .expected_first(e1), .expected_second(e2), .mixer_in(mi), .first_sample(s1),
      .second_sample(s2), .mixer_out(mo), .serial_port_four_wire_select(four),
      .mixer_enable(mix), .coarse_mix_enable(coarse), .nco_enable(nco),
      .current_scale(scale), .clock_gone_enables(gone), .transmit_enable(txen));

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic summarize;
      if (bad_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // register access by index
   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      logic [31:0] x;
      host.xfer(1'b1, {24'h0, idx, 2'b00}, {16'h0, d}, x);
   endtask

   task automatic rd(input logic [5:0] idx, output logic [31:0] d);
      host.xfer(1'b0, {24'h0, idx, 2'b00}, 32'h0, d);
   endtask

   // expected conditioned sample
   function automatic logic [15:0] exp_sample(input logic [15:0] raw, input logic rev,
      input logic twos);
      logic [15:0] v;
      v = raw;
      if (rev)
      begin
         for (int k = 0; k < 16; k++)
            v[k] = raw[15-k];
      end
      if (!twos)
         v[15] = ~v[15];
      return v;
   endfunction

   // expected mixer output, saturating on gain
   function automatic logic [15:0] exp_mix(input logic [15:0] x, input logic en, input logic g);
      if (!en)
         return 16'h0000;
      if (!g)
         return x;
      if (x[15] != x[14])
         return x[15] ? 16'h8000 : 16'h7fff;
      return {x[14:0], 1'b0};
   endfunction

   // watchdog
   initial
   begin
      #(40 * 20000);
      bad_count++;
      summarize();
   end

   // main sequence
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`DDC_IDX_FORMAT, q);
      check(q, 32'h7000);
      rd(`DDC_IDX_SCALE, q);
      check(q, 32'hf000);
      rd(6'h3f, q);
      check(q, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
         r = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
         // reserved bits always written as zeros
         wr(`DDC_IDX_FORMAT, r[15:0] & `DDC_FMT_WMASK);
         wr(`DDC_IDX_SCALE, r[31:16] & `DDC_SCL_WMASK);
         rd(`DDC_IDX_FORMAT, q);
         check(q, {16'h0, r[15:0] & `DDC_FMT_WMASK});
         rd(`DDC_IDX_SCALE, q);
         check(q, {16'h0, r[31:16] & `DDC_SCL_WMASK});
         check({four, mix, nco}, {r[7], r[6], r[4]});
         check(scale, r[31:28]);
         check(txen, r[16]);
         check(gone, r[14:12]);
         check(hresp, `DDC_AHB_OKAY);
         b1 <= 16'($random(seed));
         b2 <= 16'($random(seed));
         mi <= 16'($random(seed));
         repeat (4) @(posedge hclk);
         check(s1, exp_sample(b1, r[3], r[1]));
         check(s2, exp_sample(b2, r[3], r[1]));
         check(mo, exp_mix(mi, r[6], r[5]));
      end
      wr(`DDC_IDX_SCALE, 16'h0000);
      pin <= 1'b1;
      repeat (4) @(posedge hclk);
      check(txen, 1'b1);
      pin <= 1'b0;
      repeat (4) @(posedge hclk);
      check(txen, 1'b0);
      e1 <= b1 ^ 16'h0081;
      e2 <= b2 ^ 16'h0100;
      act <= 1'b1;
      @(posedge hclk);
      act <= 1'b0;
      rd(`DDC_IDX_RESULT, q);
      check(q, 32'h0181);
      // software clears one recorded failure
      wr(`DDC_IDX_RESULT, 16'h0001);
      rd(`DDC_IDX_RESULT, q);
      check(q, 32'h0180);
      summarize();
   end
endmodule

`default_nettype wire
